// File: hw/tspc_defs.svh
`ifndef TSPC_DEFS_SVH
`define TSPC_DEFS_SVH

// ****************************************************************
// Register byte offsets.
// ****************************************************************
`define TSPC_OFF_GLOBAL     12'h000
`define TSPC_OFF_REC_CTRL   12'h004
`define TSPC_OFF_REC_LEN    12'h008
`define TSPC_OFF_REC_START  12'h00c
`define TSPC_OFF_REC_STS    12'h010
`define TSPC_OFF_REC_ENA    12'h014
`define TSPC_OFF_TSO_CTRL   12'h018
`define TSPC_OFF_REC_TOP    12'h01c
`define TSPC_OFF_REC_PTR    12'h020
`define TSPC_OFF_CHAN_CTRL  12'h100
`define TSPC_OFF_LIST_CFG   12'h104
`define TSPC_OFF_LIST_BASE  12'h108
`define TSPC_OFF_LIST_SW    12'h10c
`define TSPC_OFF_LIST_HW    12'h110
`define TSPC_OFF_DONE_LOW   12'h114

// ****************************************************************
// Field positions.
// ****************************************************************
`define TSPC_REC_START_BIT  0
`define TSPC_REC_STOP_BIT   1
`define TSPC_STS_DONE_BIT   0
`define TSPC_STS_ERR_BIT    1
`define TSPC_STS_PAGE_BIT   2
`define TSPC_CHAN_CLR_BIT   0
`define TSPC_LIST_START_BIT 0
`define TSPC_LIST_STOP_BIT  1
`define TSPC_LIST_PAUSE_BIT 2
`define TSPC_LIST_DONE_BIT  3
`define TSPC_IN_SWAP_BIT    7
`define TSPC_OUT_SWAP_BIT   8
`define TSPC_CLK_INV_BIT    18

// ****************************************************************
// Reset value and counts.
// ****************************************************************
`define TSPC_RESET_WORD     32'h0000_0000
`define TSPC_CLEAR_CYCLES   4'h8
`define TSPC_WORD_BYTES     32'h0000_0004
`define TSPC_LIST_DEPTH     8'h40

`endif

// File: hw/tspc_pkg.sv
package tspc_pkg;

   // Configuration handed to the stream, recorder and list DMA logic.
   typedef struct packed {
      logic        filter_channel0_enable;
      logic        filter_channel1_enable;
      logic        recorder_on;
      logic        output_on;
      logic [2:0]  arbiter_count;
      logic        rec_fixed_addr;
      logic [1:0]  rec_burst;
      logic [1:0]  rec_source;
      logic        tso_data_on_bit0;
      logic        tso_clock_invert;
      logic        tso_parallel;
      logic        tso_lsb_first;
      logic [1:0]  tso_source;
      logic        tso_run;
      logic        tsi_data_on_bit0;
      logic [1:0]  tsi_error_mode;
      logic        tsi_clock_invert;
      logic [1:0]  demux_burst;
      logic        sync_bypass;
      logic        key_word_order;
      logic        descrambler_conformance_enable;
      logic [1:0]  tsi_mode;
      logic        tsi_lsb_first;
      logic        high_speed_converter_port;
      logic [2:0]  unlock_count;
      logic [2:0]  lock_count;
      logic [1:0]  list_threshold;
      logic [1:0]  list_burst;
      logic        hardware_kick_select;
      logic        list_fixed_addr;
      logic        list_pause;
      logic [31:0] list_base;
      logic [7:0]  list_sw_count;
   } tspc_cfg_s;

   // Whole register state of the bank.
   typedef struct packed {
      logic [6:0]  global_cfg;
      logic [6:0]  rec_ctrl;
      logic [31:0] rec_len;
      logic [31:0] rec_start;
      logic [31:0] rec_top;
      logic [31:0] rec_ptr;
      logic [31:0] rec_count;
      logic [2:0]  rec_sts;
      logic [2:0]  rec_ena;
      logic [6:0]  tso_ctrl;
      logic [21:0] chan_ctrl;
      logic [3:0]  clr_count;
      logic [9:0]  list_cfg;
      logic [31:0] list_base;
      logic [7:0]  list_sw;
      logic [7:0]  list_hw;
      logic [31:0] done_low;
      logic [31:0] prdata;
      logic [1:0]  tsi_sync;
      logic        tsi_prev;
      logic        tsi_strobe;
      logic [31:0] in_word;
      logic [31:0] mem_word;
   } tspc_state_s;

endpackage : tspc_pkg

// File: hw/tspc_regs.sv
// Register access over APB was decided locally.
`timescale 1ns/1ps
`include "tspc_defs.svh"

module tspc_regs (
   // Clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // APB slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // Recorder DMA engine
   input  wire logic                  rec_word_ack,
   input  wire logic                  rec_burst_end,
   input  wire logic                  rec_bus_error,
   output logic                       rec_run,
   output logic      [31:0]           rec_write_addr,
   output logic                       rec_irq,
   // List DMA engine
   input  wire logic                  list_burst_end,
   input  wire logic                  list_desc_done,
   input  wire logic                  list_finished,
   output logic                       list_start,
   output logic                       list_stop,
   output logic                       list_threshold_hit,
   // Filter channel
   input  wire logic [31:0]           pid_done_set,
   output logic                       chan_soft_reset,
   output tspc_pkg::tspc_cfg_s        cfg,
   // Stream input pins and words
   input  wire logic                  tsi_clk,
   input  wire logic [31:0]           stream_word,
   input  wire logic [31:0]           memory_word,
   output logic                       tsi_sample,
   output logic      [31:0]           stream_word_out,
   output logic      [31:0]           memory_word_out
);
   import tspc_pkg::*;

   tspc_state_s r_reg;
   tspc_state_s r_next;

   logic        acc_wr;
   logic        acc_rd;
   logic        mapped;
   logic [31:0] rd_word;

   function automatic logic [31:0] tspc_swap(input logic [31:0] w);
      tspc_swap = {w[7:0], w[15:8], w[23:16], w[31:24]};
   endfunction : tspc_swap

   // ****************************************************************
   // Bus decode.
   // ****************************************************************
   // Read data is captured in the setup cycle, so the access phase
   // completes with no wait state and prdata still comes from a flop.
   assign acc_wr  = psel & penable & pwrite;
   assign acc_rd  = psel & ~penable & ~pwrite;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata  = r_reg.prdata;

   always_comb begin
      mapped  = 1'b1;
      rd_word = `TSPC_RESET_WORD;
      case (paddr)
         `TSPC_OFF_GLOBAL:    rd_word = {25'h0, r_reg.global_cfg};
         `TSPC_OFF_REC_CTRL:  rd_word = {25'h0, r_reg.rec_ctrl};
         `TSPC_OFF_REC_LEN:   rd_word = r_reg.rec_len;
         `TSPC_OFF_REC_START: rd_word = r_reg.rec_start;
         `TSPC_OFF_REC_STS:   rd_word = {29'h0, r_reg.rec_sts};
         `TSPC_OFF_REC_ENA:   rd_word = {29'h0, r_reg.rec_ena};
         `TSPC_OFF_TSO_CTRL:  rd_word = {25'h0, r_reg.tso_ctrl};
         `TSPC_OFF_REC_TOP:   rd_word = r_reg.rec_top;
         `TSPC_OFF_REC_PTR:   rd_word = r_reg.rec_ptr;
         `TSPC_OFF_CHAN_CTRL: rd_word = {10'h0, r_reg.chan_ctrl};
         `TSPC_OFF_LIST_CFG:  rd_word = {22'h0, r_reg.list_cfg};
         `TSPC_OFF_LIST_BASE: rd_word = r_reg.list_base;
         `TSPC_OFF_LIST_SW:   rd_word = {24'h0, r_reg.list_sw};
         `TSPC_OFF_LIST_HW:   rd_word = {24'h0, r_reg.list_hw};
         `TSPC_OFF_DONE_LOW:  rd_word = r_reg.done_low;
         default:             mapped = 1'b0;
      endcase
   end

   // ****************************************************************
   // Next-state logic.
   // ****************************************************************
   always_comb begin
      logic [2:0]  sts_set;
      logic [31:0] cnt_step;
      logic        rec_busy;
      logic        rec_wr;
      sts_set  = 3'h0;
      cnt_step = r_reg.rec_count + `TSPC_WORD_BYTES;
      rec_busy = r_reg.rec_ctrl[`TSPC_REC_START_BIT];
      rec_wr   = acc_wr & (paddr == `TSPC_OFF_REC_CTRL);
      r_next   = r_reg;

      if (acc_rd) begin
         r_next.prdata = rd_word;
      end

      // ---------------- Recorder engine ----------------
      if (rec_busy && rec_word_ack) begin
         r_next.rec_count = cnt_step;
         if (!r_reg.rec_ctrl[6]) begin
            r_next.rec_ptr = r_reg.rec_ptr + `TSPC_WORD_BYTES;
         end
         if (cnt_step >= r_reg.rec_len) begin
            sts_set[`TSPC_STS_DONE_BIT] = 1'b1;
            r_next.rec_ctrl[`TSPC_REC_START_BIT] = 1'b0;
            r_next.rec_ctrl[`TSPC_REC_STOP_BIT]  = 1'b0;
         end
      end
      if (rec_busy && r_reg.rec_ctrl[`TSPC_REC_STOP_BIT] && rec_burst_end) begin
         r_next.rec_ctrl[`TSPC_REC_START_BIT] = 1'b0;
         r_next.rec_ctrl[`TSPC_REC_STOP_BIT]  = 1'b0;
      end
      if (rec_busy && rec_bus_error) begin
         sts_set[`TSPC_STS_ERR_BIT] = 1'b1;
      end
      if (rec_busy && ((r_reg.rec_ptr >= r_reg.rec_start + {1'b0, r_reg.rec_top[31:1]})
                       || (r_reg.rec_ptr >= r_reg.rec_top))) begin
         sts_set[`TSPC_STS_PAGE_BIT] = 1'b1;
      end

      if (rec_wr) begin
         r_next.rec_ctrl[6:2] = pwdata[6:2];
         if (pwdata[`TSPC_REC_START_BIT] && !rec_busy) begin
            r_next.rec_ctrl[`TSPC_REC_START_BIT] = 1'b1;
            r_next.rec_ptr   = r_reg.rec_start;
            r_next.rec_count = `TSPC_RESET_WORD;
         end
         if (pwdata[`TSPC_REC_STOP_BIT] && rec_busy) begin
            r_next.rec_ctrl[`TSPC_REC_STOP_BIT] = 1'b1;
         end
      end

      if (acc_wr && paddr == `TSPC_OFF_REC_STS) begin
         r_next.rec_sts = r_reg.rec_sts & ~pwdata[2:0];
      end
      // A flag raised in the clearing cycle survives.
      r_next.rec_sts = r_next.rec_sts | sts_set;

      // ---------------- Plain software registers ----------------
      if (acc_wr) begin
         case (paddr)
            `TSPC_OFF_GLOBAL:    r_next.global_cfg = pwdata[6:0];
            `TSPC_OFF_REC_LEN:   r_next.rec_len   = pwdata;
            `TSPC_OFF_REC_START: r_next.rec_start = pwdata;
            `TSPC_OFF_REC_ENA:   r_next.rec_ena   = pwdata[2:0];
            `TSPC_OFF_TSO_CTRL:  r_next.tso_ctrl  = pwdata[6:0];
            `TSPC_OFF_REC_TOP:   r_next.rec_top   = pwdata;
            `TSPC_OFF_LIST_BASE: r_next.list_base = pwdata;
            `TSPC_OFF_LIST_SW:   r_next.list_sw   = pwdata[7:0];
            default: begin
            end
         endcase
      end

      // ---------------- Filter channel control ----------------
      if (r_reg.chan_ctrl[`TSPC_CHAN_CLR_BIT]) begin
         r_next.clr_count = r_reg.clr_count - 4'h1;
         if (r_reg.clr_count == 4'h1) begin
            r_next.chan_ctrl[`TSPC_CHAN_CLR_BIT] = 1'b0;
         end
      end
      if (acc_wr && paddr == `TSPC_OFF_CHAN_CTRL) begin
         r_next.chan_ctrl[21:1] = pwdata[21:1];
         if (pwdata[`TSPC_CHAN_CLR_BIT] && !r_reg.chan_ctrl[`TSPC_CHAN_CLR_BIT]) begin
            r_next.chan_ctrl[`TSPC_CHAN_CLR_BIT] = 1'b1;
            r_next.clr_count = `TSPC_CLEAR_CYCLES;
         end
      end

      // ---------------- List DMA control ----------------
      // start one cycle
      r_next.list_cfg[`TSPC_LIST_START_BIT] = 1'b0;
      if (r_reg.list_cfg[`TSPC_LIST_STOP_BIT] && list_burst_end) begin
         r_next.list_cfg[`TSPC_LIST_STOP_BIT] = 1'b0;
      end
      if (list_desc_done) begin
         r_next.list_hw = r_reg.list_hw + 8'h1;
      end
      if (list_finished) begin
         r_next.list_cfg[`TSPC_LIST_DONE_BIT] = 1'b0;
      end
      if (acc_wr && paddr == `TSPC_OFF_LIST_CFG) begin
         r_next.list_cfg[9:4] = pwdata[9:4];
         r_next.list_cfg[`TSPC_LIST_PAUSE_BIT] = pwdata[`TSPC_LIST_PAUSE_BIT];
         if (pwdata[`TSPC_LIST_START_BIT]) begin
            r_next.list_cfg[`TSPC_LIST_START_BIT] = 1'b1;
            r_next.list_hw = 8'h0;
         end
         if (pwdata[`TSPC_LIST_STOP_BIT]) begin
            r_next.list_cfg[`TSPC_LIST_STOP_BIT] = 1'b1;
         end
         if (pwdata[`TSPC_LIST_DONE_BIT] && !list_finished) begin
            r_next.list_cfg[`TSPC_LIST_DONE_BIT] = 1'b1;
         end
      end

      // ---------------- Done status, set wins ----------------
      if (acc_wr && paddr == `TSPC_OFF_DONE_LOW) begin
         r_next.done_low = r_reg.done_low & ~pwdata;
      end
      r_next.done_low = r_next.done_low | pid_done_set;

      // ---------------- Stream input sampling ----------------
      r_next.tsi_sync = {r_reg.tsi_sync[0], tsi_clk};
      r_next.tsi_prev = r_reg.tsi_sync[1];
      if (r_reg.chan_ctrl[`TSPC_CLK_INV_BIT]) begin
         r_next.tsi_strobe = r_reg.tsi_prev & ~r_reg.tsi_sync[1];
      end else begin
         r_next.tsi_strobe = ~r_reg.tsi_prev & r_reg.tsi_sync[1];
      end
      r_next.in_word  = r_reg.chan_ctrl[`TSPC_IN_SWAP_BIT] ? tspc_swap(stream_word)
                                                           : stream_word;
      r_next.mem_word = r_reg.chan_ctrl[`TSPC_OUT_SWAP_BIT] ? tspc_swap(memory_word)
                                                            : memory_word;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   // ****************************************************************
   // Outputs.
   // ****************************************************************
   assign rec_run         = r_reg.rec_ctrl[`TSPC_REC_START_BIT];
   assign rec_write_addr  = r_reg.rec_ptr;
   assign rec_irq         = |(r_reg.rec_sts & r_reg.rec_ena);
   assign list_start      = r_reg.list_cfg[`TSPC_LIST_START_BIT];
   assign list_stop       = r_reg.list_cfg[`TSPC_LIST_STOP_BIT];
   assign list_threshold_hit = (r_reg.list_hw >= (`TSPC_LIST_DEPTH >> r_reg.list_cfg[9:8]))
                               && (r_reg.list_hw != 8'h0);
   assign chan_soft_reset = r_reg.chan_ctrl[`TSPC_CHAN_CLR_BIT];
   assign tsi_sample      = r_reg.tsi_strobe;
   assign stream_word_out = r_reg.in_word;
   assign memory_word_out = r_reg.mem_word;

   always_comb begin
      cfg.filter_channel0_enable         = r_reg.global_cfg[0];
      cfg.filter_channel1_enable         = r_reg.global_cfg[1];
      cfg.recorder_on                    = r_reg.global_cfg[2];
      cfg.output_on                      = r_reg.global_cfg[3];
      cfg.arbiter_count                  = r_reg.global_cfg[6:4];
      cfg.rec_fixed_addr                 = r_reg.rec_ctrl[6];
      cfg.rec_burst                      = r_reg.rec_ctrl[5:4];
      cfg.rec_source                     = r_reg.rec_ctrl[3:2];
      cfg.tso_data_on_bit0               = r_reg.tso_ctrl[6];
      cfg.tso_clock_invert               = r_reg.tso_ctrl[5];
      cfg.tso_parallel                   = r_reg.tso_ctrl[4];
      // Bit order means nothing in parallel mode.
      cfg.tso_lsb_first                  = r_reg.tso_ctrl[3] & ~r_reg.tso_ctrl[4];
      cfg.tso_source                     = r_reg.tso_ctrl[2:1];
      cfg.tso_run                        = r_reg.tso_ctrl[0];
      cfg.tsi_data_on_bit0               = r_reg.chan_ctrl[21];
      cfg.tsi_error_mode                 = r_reg.chan_ctrl[20:19];
      cfg.tsi_clock_invert               = r_reg.chan_ctrl[18];
      cfg.demux_burst                    = r_reg.chan_ctrl[17:16];
      cfg.sync_bypass                    = r_reg.chan_ctrl[15];
      cfg.key_word_order                 = r_reg.chan_ctrl[14];
      cfg.descrambler_conformance_enable = r_reg.chan_ctrl[13];
      cfg.tsi_mode                       = r_reg.chan_ctrl[12:11];
      cfg.tsi_lsb_first                  = r_reg.chan_ctrl[10];
      cfg.high_speed_converter_port      = r_reg.chan_ctrl[9];
      cfg.unlock_count                   = r_reg.chan_ctrl[6:4];
      cfg.lock_count                     = r_reg.chan_ctrl[3:1];
      cfg.list_threshold                 = r_reg.list_cfg[9:8];
      cfg.list_burst                     = r_reg.list_cfg[7:6];
      cfg.hardware_kick_select           = r_reg.list_cfg[5];
      cfg.list_fixed_addr                = r_reg.list_cfg[4];
      cfg.list_pause                     = r_reg.list_cfg[`TSPC_LIST_PAUSE_BIT];
      cfg.list_base                      = r_reg.list_base;
      cfg.list_sw_count                  = r_reg.list_sw;
   end

endmodule : tspc_regs

// File: tb/tspc_partner.sv
`timescale 1ns/1ps
// ****
// Recorder bus partner and link clock.
// ****
module tspc_partner (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Bench commands
   input  wire logic       go,
   input  wire logic       slow,
   input  wire logic       err_cmd,
   input  wire logic       link_en,
   input  wire logic [3:0] words,
   // Recorder side
   input  wire logic       rec_run,
   output logic            rec_word_ack,
   output logic            rec_burst_end,
   output logic            rec_bus_error,
   output logic            tsi_clk
);
   import tspc_pkg::*;
   logic [3:0] left_reg;
   logic       phase_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         left_reg      <= 4'h0;
         phase_reg     <= 1'b0;
         rec_word_ack  <= 1'b0;
         rec_burst_end <= 1'b0;
         rec_bus_error <= 1'b0;
      end else begin
         phase_reg     <= ~phase_reg;
         rec_word_ack  <= 1'b0;
         rec_burst_end <= 1'b0;
         rec_bus_error <= err_cmd & rec_run;
         if (go) begin
            left_reg <= words;
         end else if (left_reg != 4'h0 && (!slow || phase_reg)) begin
            left_reg      <= left_reg - 4'h1;
            rec_word_ack  <= 1'b1;
            rec_burst_end <= (left_reg == 4'h1);
         end
      end
   end
   initial begin
      tsi_clk = 1'b0;
      #1.3;
      forever #24 if (link_en) tsi_clk = ~tsi_clk;
   end
endmodule : tspc_partner

// File: tb/tspc_regs_assertions.sv
`timescale 1ns/1ps
module tspc_regs_assertions (
   // Clock, reset and bus
   input wire logic                pclk,
   input wire logic                presetn,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [11:0]         paddr,
   input wire logic [31:0]         pwdata,
   input wire logic                pslverr,
   // Engines and stream
   input wire logic                rec_word_ack,
   input wire logic                rec_burst_end,
   input wire logic                rec_run,
   input wire logic [31:0]         rec_write_addr,
   input wire logic                list_start,
   input wire logic                chan_soft_reset,
   input wire tspc_pkg::tspc_cfg_s cfg,
   input wire logic                tsi_clk,
   input wire logic                tsi_sample,
   input wire logic [31:0]         stream_word,
   input wire logic [31:0]         stream_word_out
);
   import tspc_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic       acc;
   logic       stop_q;
   logic [1:0] swap_q;
   assign acc = psel && penable && pwrite;
   function automatic logic [31:0] rev(input logic [31:0] x);
      return {x[7:0], x[15:8], x[23:16], x[31:24]};
   endfunction : rev
   // The checker keeps its own copy of the swap bits, which no port shows.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         swap_q <= 2'b00;
         stop_q <= 1'b0;
      end else begin
         if (acc && paddr == 12'h100) swap_q <= pwdata[8:7];
         if (acc && paddr == 12'h004 && pwdata[1] && rec_run) stop_q <= 1'b1;
         else if (rec_burst_end || !rec_run) stop_q <= 1'b0;
      end
   end
   AST_UNMAPPED: assert property (psel && penable && paddr == 12'h024 |-> pslverr)
      else $error("unmapped access without slave error");
   AST_START: assert property (acc && paddr == 12'h004 && pwdata[0] |=> rec_run)
      else $error("recorder did not start");
   AST_PTR_STEP: assert property (rec_run && rec_word_ack && !cfg.rec_fixed_addr
      |=> rec_write_addr == $past(rec_write_addr) + 32'h4)
      else $error("write pointer did not advance by one word");
   AST_PTR_FIXED: assert property (rec_run && rec_word_ack && cfg.rec_fixed_addr
      |=> $stable(rec_write_addr))
      else $error("fixed address pointer moved");
   AST_STOP: assert property (stop_q && rec_burst_end |=> !rec_run)
      else $error("recorder still running after burst end");
   AST_LIST_START: assert property (acc && paddr == 12'h104 && pwdata[0]
      |=> list_start ##1 !list_start)
      else $error("list start not a single pulse");
   AST_CLEAR: assert property (acc && paddr == 12'h100 && pwdata[0] && !chan_soft_reset
      |=> chan_soft_reset [*8] ##1 !chan_soft_reset)
      else $error("channel clear length wrong");
   AST_IN_SWAP: assert property (##1 stream_word_out ==
      ($past(swap_q[0]) ? rev($past(stream_word)) : $past(stream_word)))
      else $error("input word order wrong");
   AST_TSI_EDGE: assert property (($rose(tsi_clk) && !cfg.tsi_clock_invert) ||
      ($fell(tsi_clk) && cfg.tsi_clock_invert) |-> ##[1:6] tsi_sample)
      else $error("link edge not sampled");
   COV_DONE: cover property (rec_run ##1 !rec_run);
   COV_LIST: cover property (list_start);
   COV_LINK: cover property (tsi_sample);
endmodule : tspc_regs_assertions

// File: tb/ts_processor_control_regs_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin mismatches++; \
   $display("ERROR %s expected %h seen %h", n, e, s); end end
module ts_processor_control_regs_bench;
   import tspc_pkg::*;
   typedef struct packed {logic [11:0] a; logic [31:0] w; logic [31:0] e;} tspc_row_s;
   localparam tspc_row_s ROWS [13] = '{
      '{12'h000, 32'hffffffff, 32'h0000007f}, '{12'h004, 32'hffffff7c, 32'h0000007c},
      '{12'h008, 32'h00000010, 32'h00000010}, '{12'h00c, 32'h00001000, 32'h00001000},
      '{12'h014, 32'hffffffff, 32'h00000007}, '{12'h018, 32'hffffffff, 32'h0000007f},
      '{12'h01c, 32'h00001008, 32'h00001008}, '{12'h020, 32'hffffffff, 32'h00000000},
      '{12'h100, 32'hfffffffe, 32'h003ffffe}, '{12'h104, 32'hfffffff4, 32'h000003f4},
      '{12'h108, 32'h12345678, 32'h12345678}, '{12'h10c, 32'hffffffff, 32'h000000ff},
      '{12'h110, 32'hffffffff, 32'h00000000}};
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, stream_word = 32'h0, memory_word = 32'h0, rdat, prdata;
   logic [31:0] rec_write_addr, stream_word_out, memory_word_out;
   logic        pready, pslverr, rec_word_ack, rec_burst_end, rec_bus_error, rec_run, rec_irq;
   logic        list_start, list_stop, list_threshold_hit, chan_soft_reset, tsi_clk, tsi_sample;
   logic        slow = 1'b0, link_en = 1'b0, rerr;
   logic [4:0]  lev = 5'h0;
   logic [3:0]  words = 4'h4;
   tspc_cfg_s   cfg;
   int          checks = 0, mismatches = 0, cyc = 0, rises = 0, falls = 0, samples = 0;
   always #2.5 pclk = ~pclk;
   always @(posedge tsi_clk) rises++;
   always @(negedge tsi_clk) falls++;
   always @(posedge pclk) if (tsi_sample === 1'b1) samples++;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 6000) begin
         mismatches++;
         final_report;
      end
   end
   tspc_regs u_tspc_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rec_word_ack(rec_word_ack), .rec_burst_end(rec_burst_end),
      .rec_bus_error(rec_bus_error), .rec_run(rec_run), .rec_write_addr(rec_write_addr),
      .rec_irq(rec_irq), .list_burst_end(lev[0]), .list_desc_done(lev[1]),
      .list_finished(lev[2]), .list_start(list_start), .list_stop(list_stop),
      .list_threshold_hit(list_threshold_hit), .pid_done_set(32'h0),
      .chan_soft_reset(chan_soft_reset), .cfg(cfg), .tsi_clk(tsi_clk),
      .stream_word(stream_word), .memory_word(memory_word), .tsi_sample(tsi_sample),
      .stream_word_out(stream_word_out), .memory_word_out(memory_word_out));
   tspc_partner u_tspc_partner (.pclk(pclk), .presetn(presetn), .go(lev[3]), .slow(slow),
      .err_cmd(lev[4]), .link_en(link_en), .words(words), .rec_run(rec_run),
      .rec_word_ack(rec_word_ack), .rec_burst_end(rec_burst_end),
      .rec_bus_error(rec_bus_error), .tsi_clk(tsi_clk));
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk);
      while (pready !== 1'b1);
      rdat    = prdata;
      rerr    = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK($sformatf("reg %h", a), e, rdat)
   endtask : rd
   // Event lines are pulsed for one cycle, then given a cycle to land.
   task automatic pulse(input logic [4:0] m);
      @(posedge pclk);
      lev <= m;
      @(posedge pclk);
      lev <= 5'h0;
      @(posedge pclk);
      #1;
   endtask : pulse
   task automatic wait_idle;
      while (rec_run !== 1'b0) @(posedge pclk);
   endtask : wait_idle
   task final_report;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      #1 `CHK("outs", 5'h0, {rec_run, rec_irq, list_start, list_stop, chan_soft_reset})
      rd(12'h010, 32'h0);
      for (int i = 0; i < 13; i++) begin
         rd(ROWS[i].a, 32'h0);
         wr(ROWS[i].a, ROWS[i].w);
         rd(ROWS[i].a, ROWS[i].e);
      end
      `CHK("cfg", 7'h7f, {cfg.filter_channel0_enable, cfg.rec_fixed_addr, cfg.rec_burst, cfg.tso_run, cfg.list_threshold})
      apb(1'b1, 12'h024, 32'hffffffff);
      apb(1'b0, 12'h024, 32'h0);
      `CHK("slverr", 1'b1, rerr)
      `CHK("unmapped", 32'h0, rdat)
      $display("test registers done");
      wr(12'h004, 32'h0);
      wr(12'h004, 32'h1);
      @(posedge pclk);
      #1 `CHK("run", 1'b1, rec_run)
      pulse(5'h18);
      wait_idle;
      rd(12'h020, 32'h00001010);
      rd(12'h004, 32'h0);
      rd(12'h010, 32'h7);
      for (int k = 0; k < 4; k++) begin
         wr(12'h014, 32'h1 << k);
         #1 `CHK("irq", k < 3, rec_irq)
      end
      wr(12'h014, 32'h7);
      wr(12'h010, 32'h7);
      rd(12'h010, 32'h0);
      `CHK("irq", 1'b0, rec_irq)
      $display("test recorder done");
      words <= 4'h2;
      wr(12'h004, 32'h41);
      wr(12'h004, 32'h42);
      repeat (4) @(posedge pclk);
      #1 `CHK("run", 1'b1, rec_run)
      slow <= 1'b1;
      pulse(5'h08);
      wait_idle;
      rd(12'h004, 32'h40);
      rd(12'h020, 32'h00001000);
      rd(12'h010, 32'h0);
      $display("test stop done");
      wr(12'h104, 32'h3f9);
      for (int i = 1; i <= 8; i++) begin
         pulse(5'h02);
         `CHK("hit", i >= 8, list_threshold_hit)
      end
      rd(12'h110, 32'h8);
      pulse(5'h04);
      rd(12'h104, 32'h3f0);
      wr(12'h104, 32'h3f2);
      #1 `CHK("lstop", 1'b1, list_stop)
      pulse(5'h01);
      `CHK("lstop", 1'b0, list_stop)
      $display("test list done");
      wr(12'h100, 32'h181);
      rd(12'h100, 32'h181);
      repeat (10) @(posedge pclk);
      rd(12'h100, 32'h180);
      stream_word <= 32'h11223344;
      memory_word <= 32'h11223344;
      repeat (2) @(posedge pclk);
      #1 `CHK("mem", 32'h44332211, memory_word_out)
      `CHK("in", 32'h44332211, stream_word_out)
      wr(12'h100, 32'h80);
      repeat (2) @(posedge pclk);
      #1 `CHK("mem", 32'h11223344, memory_word_out)
      $display("test channel done");
      for (int v = 0; v < 2; v++) begin
         wr(12'h100, 32'(v) << 18);
         rises = 0;
         falls = 0;
         samples = 0;
         link_en <= 1'b1;
         repeat (100) @(posedge pclk);
         link_en <= 1'b0;
         repeat (12) @(posedge pclk);
         `CHK("samples", v ? falls : rises, samples)
      end
      $display("test link done");
      final_report;
   end
endmodule : ts_processor_control_regs_bench
bind tspc_regs tspc_regs_assertions u_tspc_regs_assertions (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pslverr(pslverr), .rec_word_ack(rec_word_ack), .rec_burst_end(rec_burst_end),
   .rec_run(rec_run), .rec_write_addr(rec_write_addr), .list_start(list_start),
   .chan_soft_reset(chan_soft_reset), .cfg(cfg), .tsi_clk(tsi_clk), .tsi_sample(tsi_sample),
   .stream_word(stream_word), .stream_word_out(stream_word_out));
